// ---- hw/rlc_err_cnt.sv ----
// Saturating per-lane error counter
`timescale 1ns/100ps
module rlc_err_cnt #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         en_i,
    input  wire logic         clr_i,
    input  wire logic         hit_i,
    output logic [W-1:0]      cnt_o
);
    generate
        if (W < 1) begin : g_bad_w
            $error("Counter width must be at least one");
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_o <= '0;
        end else if (en_i) begin
            // A hit in the clear cycle is kept
            if (clr_i) begin
                cnt_o <= W'(hit_i);
            end else if (hit_i && (cnt_o != '1)) begin
                cnt_o <= cnt_o + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_err_step: assert property (en_i && !clr_i && hit_i && (cnt_o != '1) |=>
        cnt_o == $past(cnt_o) + 1'b1) else $error("Error count did not step");
    a_err_hold: assert property (en_i && !clr_i && !hit_i |=> $stable(cnt_o))
        else $error("Error count moved without a hit");
endmodule

// ---- hw/rlc_lane_ctrl.sv ----
// Lane remap, polarity, equalizer choice, CDR timing and error counters
`timescale 1ns/100ps
// Overview of operation
// - Link enable low: ignore control inputs, main link outputs high impedance; eq_gain_o still follows the equalizer pin.
// - Enable toggle resets device and drops written configuration; host rewrites.
// - Operate only after link enable rises; stay inactive while low.
// - Clock recovery becomes active within 15 ms of retimer start.
// - Clock recovery shuts off within 120 ns of retimer stop.
// - Swap routes D2 to clock, D1 to D0, D0 to D1, clock to D2.
// - Only inputs remap; equalizer setting follows the remapped input.
// - Lane swap works in redriver and retimer modes.
// - Pin high or polarity bit set inverts p and n of all lanes.
// - Polarity only in retimer; automatic mode loses it below crossover.
// - Separate readable error counter for each of three data lanes.
// - Fixed equalizer in both modes, adaptive only in retimer mode.
// - Equalizer pin high 14 dB, low 7.5 dB, floating adaptive.
// - Adaptive equalizer gain follows the detected data rate.
// - Gain field selects fixed gain for data and clock lanes.
// - Automatic mode bypasses retimer when pixel clock is slow.
// - Mode field selects function; forced redriver shuts clock recovery off.
module rlc_lane_ctrl #(
    parameter int CDR_ON_C = rlc_pkg::CDR_ON_CYC,
    parameter int ERR_W    = rlc_pkg::ERR_CNT_W
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic                       en_i,
    input  wire logic                       oe_i,
    input  wire logic                       lane_remap_invert_pin_i,
    input  wire rlc_pkg::rlc_eq_pin_t       equalizer_choice_pin_i,
    input  wire logic                       pixclk_fast_i,
    input  wire logic [1:0]                 rate_class_i,
    input  wire rlc_pkg::rlc_wr_t           wr_i,
    input  wire logic [2:0]                 lane_err_i,
    input  wire logic                       err_clr_i,
    output logic                            link_oe_b_o,
    output logic                            active_o,
    output rlc_pkg::rlc_lane_map_t          lane_map_o,
    output logic                            lane_pol_inv_o,
    output logic                            cdr_en_o,
    output logic                            cdr_active_o,
    output logic                            eq_adaptive_o,
    output logic [3:0][4:0]                 eq_gain_o,
    output wire logic [2:0][ERR_W-1:0]      err_cnt_o
);
    localparam int CNT_W   = (CDR_ON_C > 2) ? $clog2(CDR_ON_C) : 1;
    localparam int OFF_LAT = rlc_pkg::CDR_OFF_CYC;
    localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(CDR_ON_C - 2);

    generate
        if (CDR_ON_C < 2) begin : g_bad_on
            $error("CDR start count must be at least two cycles");
        end
    endgenerate

    typedef enum logic [1:0] {CDR_OFF, CDR_LOCKING, CDR_ACTIVE} rlc_cdr_state_t;

    logic [7:0]       lane_ctl_reg;
    logic [7:0]       mode_ctl_reg;
    logic [7:0]       eq_gain_ctl_reg;
    logic             lane_wr_reg;
    logic             eq_wr_reg;
    logic             pol_lost_reg;
    logic [CNT_W-1:0] lock_cnt_reg;
    logic [CNT_W-1:0] lock_cnt_next;
    rlc_cdr_state_t   cdr_state_reg;
    rlc_cdr_state_t   cdr_state_next;
    logic             swap_sel;
    logic             pol_sel;
    logic             pol_next;
    logic             adapt_sel;
    logic             adapt_next;
    logic             auto_mode;
    logic             want_retimer;
    logic             pol_drop;
    logic [1:0]       fmode;
    logic [4:0]       fixed_gain;
    rlc_pkg::rlc_lane_map_t map_next;
    logic [4:0]       gain_next [4];

    function automatic logic [4:0] adapt_gain(input logic [1:0] rate);
        case (rate)
            2'h0:    adapt_gain = rlc_pkg::ADAPT_GAIN_R0;
            2'h1:    adapt_gain = rlc_pkg::ADAPT_GAIN_R1;
            2'h2:    adapt_gain = rlc_pkg::ADAPT_GAIN_R2;
            default: adapt_gain = rlc_pkg::ADAPT_GAIN_R3;
        endcase
    endfunction

    // Gain of one input lane; clock input runs at the slowest class
    function automatic logic [4:0] in_gain(input logic [1:0] lane, input logic adapt,
                                           input logic [1:0] rate, input logic [4:0] fixd);
        if (!adapt) begin
            in_gain = fixd;
        end else if (lane == rlc_pkg::LANE_CLK) begin
            in_gain = adapt_gain(2'h0);
        end else begin
            in_gain = adapt_gain(rate);
        end
    endfunction

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lane_ctl_reg    <= rlc_pkg::REG_LANE_CTL_RST;
            mode_ctl_reg    <= rlc_pkg::REG_MODE_CTL_RST;
            eq_gain_ctl_reg <= rlc_pkg::REG_EQ_GAIN_RST;
            lane_wr_reg     <= 1'b0;
            eq_wr_reg       <= 1'b0;
        end else if (en_i) begin
            if (!oe_i) begin
                lane_ctl_reg    <= rlc_pkg::REG_LANE_CTL_RST;
                mode_ctl_reg    <= rlc_pkg::REG_MODE_CTL_RST;
                eq_gain_ctl_reg <= rlc_pkg::REG_EQ_GAIN_RST;
                lane_wr_reg     <= 1'b0;
                eq_wr_reg       <= 1'b0;
            end else if (wr_i.en) begin
                case (wr_i.addr)
                    rlc_pkg::REG_LANE_CTL: begin
                        lane_ctl_reg <= wr_i.data;
                        lane_wr_reg  <= 1'b1;
                    end
                    rlc_pkg::REG_MODE_CTL: begin
                        mode_ctl_reg <= wr_i.data;
                        eq_wr_reg    <= 1'b1;
                    end
                    rlc_pkg::REG_EQ_GAIN: begin
                        eq_gain_ctl_reg <= wr_i.data;
                        eq_wr_reg       <= 1'b1;
                    end
                    default: begin
                        lane_wr_reg <= lane_wr_reg;
                    end
                endcase
            end
        end
    end

    assign swap_sel = lane_wr_reg ? lane_ctl_reg[rlc_pkg::LANE_SWAP_BIT]
                                  : !lane_remap_invert_pin_i;
    assign pol_sel  = lane_wr_reg ? lane_ctl_reg[rlc_pkg::LANE_POL_BIT]
                                  : lane_remap_invert_pin_i;

    assign fmode        = mode_ctl_reg[rlc_pkg::FUNC_MODE_LSB +: rlc_pkg::FUNC_MODE_W];
    assign auto_mode    = (fmode != rlc_pkg::FM_REDRIVER) && (fmode != rlc_pkg::FM_RETIMER);
    assign want_retimer = oe_i && ((fmode == rlc_pkg::FM_RETIMER) ||
                                   (auto_mode && pixclk_fast_i));

    always_comb begin
        adapt_sel  = 1'b0;
        fixed_gain = rlc_pkg::EQ_GAIN_7P5DB;
        if (eq_wr_reg) begin
            adapt_sel  = mode_ctl_reg[rlc_pkg::EQ_ADAPT_BIT];
            fixed_gain = eq_gain_ctl_reg[rlc_pkg::EQ_GAIN_LSB +: rlc_pkg::EQ_GAIN_W];
        end else begin
            case (equalizer_choice_pin_i)
                rlc_pkg::EQP_HIGH:  fixed_gain = rlc_pkg::EQ_GAIN_14DB;
                rlc_pkg::EQP_FLOAT: adapt_sel  = 1'b1;
                default:            fixed_gain = rlc_pkg::EQ_GAIN_7P5DB;
            endcase
        end
    end

    always_comb begin
        cdr_state_next = cdr_state_reg;
        lock_cnt_next  = lock_cnt_reg;
        case (cdr_state_reg)
            CDR_OFF: begin
                if (want_retimer) begin
                    cdr_state_next = CDR_LOCKING;
                    lock_cnt_next  = '0;
                end
            end
            CDR_LOCKING: begin
                if (!want_retimer) begin
                    cdr_state_next = CDR_OFF;
                end else if (lock_cnt_reg == LOCK_LAST) begin
                    cdr_state_next = CDR_ACTIVE;
                end else begin
                    lock_cnt_next = lock_cnt_reg + 1'b1;
                end
            end
            CDR_ACTIVE: begin
                if (!want_retimer) begin
                    cdr_state_next = CDR_OFF;
                end
            end
            default: cdr_state_next = CDR_OFF;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cdr_state_reg <= CDR_OFF;
            lock_cnt_reg  <= '0;
        end else if (en_i) begin
            cdr_state_reg <= cdr_state_next;
            lock_cnt_reg  <= lock_cnt_next;
        end
    end

    assign pol_drop = oe_i && auto_mode && (cdr_state_reg == CDR_ACTIVE) && !pixclk_fast_i;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pol_lost_reg <= 1'b0;
        end else if (en_i) begin
            // Set wins over a rewrite in the same cycle
            if (pol_drop) begin
                pol_lost_reg <= 1'b1;
            end else if (!oe_i || (wr_i.en && (wr_i.addr == rlc_pkg::REG_LANE_CTL))) begin
                pol_lost_reg <= 1'b0;
            end
        end
    end

    assign pol_next   = oe_i && pol_sel && !pol_lost_reg && (cdr_state_next == CDR_ACTIVE);
    assign adapt_next = oe_i && adapt_sel && (cdr_state_next == CDR_ACTIVE);
    assign map_next   = (oe_i && swap_sel) ? rlc_pkg::MAP_SWAP : rlc_pkg::MAP_NORMAL;

    generate
        for (genvar o = 0; o < 4; o++) begin : g_gain
            assign gain_next[o] = in_gain(map_next[o], adapt_next, rate_class_i, fixed_gain);
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            link_oe_b_o    <= 1'b1;
            active_o       <= 1'b0;
            lane_map_o     <= rlc_pkg::MAP_NORMAL;
            lane_pol_inv_o <= 1'b0;
            eq_adaptive_o  <= 1'b0;
            for (int o = 0; o < 4; o++) begin
                eq_gain_o[o] <= rlc_pkg::EQ_GAIN_7P5DB;
            end
        end else if (en_i) begin
            link_oe_b_o    <= !oe_i;
            active_o       <= oe_i;
            lane_map_o     <= map_next;
            lane_pol_inv_o <= pol_next;
            eq_adaptive_o  <= adapt_next;
            for (int o = 0; o < 4; o++) begin
                eq_gain_o[o] <= gain_next[o];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cdr_en_o     <= 1'b0;
            cdr_active_o <= 1'b0;
        end else if (en_i) begin
            cdr_en_o     <= (cdr_state_next != CDR_OFF);
            cdr_active_o <= (cdr_state_next == CDR_ACTIVE);
        end
    end

    generate
        for (genvar k = 0; k < 3; k++) begin : g_err
            rlc_err_cnt #(
                .W (ERR_W)
            ) u_err (
                .clk_i   (clk_i),
                .rst_b_i (rst_b_i),
                .en_i    (en_i),
                .clr_i   (err_clr_i || !oe_i),
                .hit_i   (lane_err_i[k] && oe_i),
                .cnt_o   (err_cnt_o[k])
            );
        end
    endgenerate

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_hiz_oe_low: assert property (en_i && !oe_i |=> link_oe_b_o && !cdr_en_o)
        else $error("Link not idle while enable low");
    a_idle_oe_low: assert property (en_i && !oe_i |=> !active_o &&
        (lane_map_o == rlc_pkg::MAP_NORMAL) && !lane_pol_inv_o)
        else $error("Device active while enable low");
    a_reg_default: assert property (en_i && !oe_i |=> !lane_wr_reg && !eq_wr_reg)
        else $error("Written config survived reset");
    a_cdr_on_bound: assert property (lock_cnt_reg <= LOCK_LAST)
        else $error("CDR start count overran");
    a_cdr_on_time: assert property (en_i && want_retimer &&
        (cdr_state_reg == CDR_LOCKING) && (lock_cnt_reg == LOCK_LAST) |=> cdr_active_o)
        else $error("CDR not active in time");
    a_cdr_off_time: assert property (en_i && cdr_en_o && !want_retimer |->
        ##[1:OFF_LAT] !cdr_en_o) else $error("CDR shutoff late");
    a_swap_map: assert property (en_i && oe_i && swap_sel |=>
        lane_map_o == rlc_pkg::MAP_SWAP) else $error("Swap routing wrong");
    a_reg_wins: assert property (en_i && oe_i && lane_wr_reg &&
        !lane_ctl_reg[rlc_pkg::LANE_SWAP_BIT] |=> lane_map_o == rlc_pkg::MAP_NORMAL)
        else $error("Strap overrode written swap bit");
    a_pol_retimer: assert property (lane_pol_inv_o |-> cdr_active_o)
        else $error("Polarity inverted outside retimer");
    a_pol_apply: assert property (en_i && pol_sel && oe_i && !pol_lost_reg &&
        (cdr_state_next == CDR_ACTIVE) |=> lane_pol_inv_o)
        else $error("Polarity select not applied");
    a_eq_pin_hi: assert property (en_i && oe_i && !eq_wr_reg &&
        (equalizer_choice_pin_i == rlc_pkg::EQP_HIGH) |=>
        (eq_gain_o[0] == rlc_pkg::EQ_GAIN_14DB) && !eq_adaptive_o)
        else $error("Equalizer pin high not 14 dB");
    a_adapt_mode: assert property (eq_adaptive_o |-> cdr_active_o)
        else $error("Adaptive equalizer outside retimer");
    a_auto_redrv: assert property (en_i && oe_i && auto_mode && !pixclk_fast_i
        |=> !cdr_en_o) else $error("Retimer kept at slow clock");
    a_forced_redrv: assert property (en_i && (fmode == rlc_pkg::FM_REDRIVER)
        |=> !cdr_en_o) else $error("CDR on in forced redriver");

    c_swap: cover property (en_i ##1 lane_map_o == rlc_pkg::MAP_SWAP);
    c_cdr_active: cover property ($rose(cdr_active_o));
    c_pol: cover property ($rose(lane_pol_inv_o));
    c_adapt: cover property (eq_adaptive_o && cdr_active_o);
endmodule

// ---- hw/rlc_pkg.sv ----
// Shared constants and types for the lane configuration controller
package rlc_pkg;
    // Timing, figures in their own units, then in cycles
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_CDR_ON_MS   = 15;
    localparam int CDR_ON_CYC    = T_CDR_ON_MS * 1000000 / CLK_PERIOD_NS;
    localparam int T_CDR_OFF_NS  = 120;
    localparam int CDR_OFF_RAW   = T_CDR_OFF_NS / CLK_PERIOD_NS;
    localparam int CDR_OFF_CYC   = (CDR_OFF_RAW < 1) ? 1 : CDR_OFF_RAW;

    // Register map, offsets and fields
    localparam logic [7:0] REG_LANE_CTL     = 8'h09;
    localparam int         LANE_SWAP_BIT    = 7;
    localparam int         LANE_POL_BIT     = 6;
    localparam logic [7:0] REG_MODE_CTL     = 8'h0A;
    localparam int         EQ_ADAPT_BIT     = 5;
    localparam int         FUNC_MODE_LSB    = 0;
    localparam int         FUNC_MODE_W      = 2;
    localparam logic [7:0] REG_EQ_GAIN      = 8'h0D;
    localparam int         EQ_GAIN_LSB      = 1;
    localparam int         EQ_GAIN_W        = 5;
    localparam logic [7:0] REG_LANE_CTL_RST = 8'h00;
    localparam logic [7:0] REG_MODE_CTL_RST = 8'h00;
    localparam logic [7:0] REG_EQ_GAIN_RST  = 8'h1E;

    // Function modes; the spare code behaves as automatic
    localparam logic [1:0] FM_AUTO     = 2'h0;
    localparam logic [1:0] FM_REDRIVER = 2'h1;
    localparam logic [1:0] FM_RETIMER  = 2'h2;

    // Equalizer gain codes
    localparam logic [4:0] EQ_GAIN_14DB  = 5'h1C;
    localparam logic [4:0] EQ_GAIN_7P5DB = 5'h0F;
    localparam logic [4:0] ADAPT_GAIN_R0 = 5'h08;
    localparam logic [4:0] ADAPT_GAIN_R1 = 5'h10;
    localparam logic [4:0] ADAPT_GAIN_R2 = 5'h18;
    localparam logic [4:0] ADAPT_GAIN_R3 = 5'h1F;

    // Input lane indices; map element index is the output lane
    localparam logic [1:0] LANE_D0  = 2'h0;
    localparam logic [1:0] LANE_D1  = 2'h1;
    localparam logic [1:0] LANE_D2  = 2'h2;
    localparam logic [1:0] LANE_CLK = 2'h3;

    typedef logic [3:0][1:0] rlc_lane_map_t;

    localparam rlc_lane_map_t MAP_NORMAL = {LANE_CLK, LANE_D2, LANE_D1, LANE_D0};
    localparam rlc_lane_map_t MAP_SWAP   = {LANE_D2, LANE_CLK, LANE_D0, LANE_D1};

    localparam int ERR_CNT_W = 8;

    typedef enum logic [1:0] {EQP_LOW, EQP_HIGH, EQP_FLOAT} rlc_eq_pin_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } rlc_wr_t;
endpackage

// ---- verif/rlc_host_model.sv ----
// Host side model: drives link enable with a clean low period
`timescale 1ns/100ps
module rlc_host_model #(
    parameter int LOW_CYC = 1000
) (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic toggle_i,
    output logic      oe_o
);
    int cnt = 0;
    // enable held low
    // Combinational so the pin is defined from time zero
    assign oe_o = rst_b_i && (cnt >= LOW_CYC);
    always @(negedge clk_i) begin
        if (!rst_b_i || toggle_i) begin
            cnt <= 0;
        end else if (cnt < LOW_CYC) begin
            cnt <= cnt + 1;
        end
    end
endmodule

// ---- verif/rlc_lane_ctrl_bench.sv ----
// Self-checking bench for the lane configuration controller
`timescale 1ns/100ps
module rlc_lane_ctrl_bench;
    localparam int CON  = 6;
    localparam int LOWC = 1000;
    logic                   clk_i = 1'b0;
    logic                   rst_b_i = 1'b0;
    logic                   oe_i;
    logic                   toggle = 1'b0;
    logic                   pin = 1'b1;
    rlc_pkg::rlc_eq_pin_t   eqp = rlc_pkg::EQP_HIGH;
    logic                   fast = 1'b0;
    logic [1:0]             rate = 2'h0;
    rlc_pkg::rlc_wr_t       wr = '0;
    logic [2:0]             lerr = 3'h0;
    logic                   clr = 1'b0;
    logic                   ce = 1'b1;
    logic                   loe_b, act, pol, cdr_en, cdr_act, adapt;
    rlc_pkg::rlc_lane_map_t lmap;
    logic [3:0][4:0]        gain;
    logic [2:0][7:0]        ecnt;
    logic [4:0]             g;
    int                     mismatches = 0;
    int                     total_checks = 0;
    int                     n;
    int                     exp_c [3] = '{0, 0, 0};

    always #50 clk_i = ~clk_i;

    rlc_host_model #(.LOW_CYC(LOWC)) u_rlc_host_model (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .toggle_i(toggle), .oe_o(oe_i));

    rlc_lane_ctrl #(.CDR_ON_C(CON), .ERR_W(8)) u_rlc_lane_ctrl (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(ce), .oe_i(oe_i),
        .lane_remap_invert_pin_i(pin), .equalizer_choice_pin_i(eqp),
        .pixclk_fast_i(fast), .rate_class_i(rate), .wr_i(wr), .lane_err_i(lerr),
        .err_clr_i(clr), .link_oe_b_o(loe_b), .active_o(act), .lane_map_o(lmap),
        .lane_pol_inv_o(pol), .cdr_en_o(cdr_en), .cdr_active_o(cdr_act),
        .eq_adaptive_o(adapt), .eq_gain_o(gain), .err_cnt_o(ecnt));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("Checks made %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic step(input int k);
        repeat (k) @(negedge clk_i);
    endtask

    // One idle cycle after each strobe keeps the driver single-assign
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr <= {1'b1, a, d};
        step(1);
        wr <= '0;
        step(1);
    endtask

    task automatic wait_cdr(input logic lvl);
        n = 0;
        while (cdr_act !== lvl) begin
            step(1);
            n++;
            if (n > CON + 20) begin
                check("cdr_wait", 1, 0);
                end_of_test();
            end
        end
    endtask

    task automatic wait_oe();
        n = 0;
        while (oe_i !== 1'b1) begin
            step(1);
            n++;
            if (n > LOWC + 20) begin
                check("oe_wait", 1, 0);
                end_of_test();
            end
        end
    endtask

    function automatic rlc_pkg::rlc_lane_map_t exp_map(input logic sw);
        if (sw) begin
            return {rlc_pkg::LANE_D2, rlc_pkg::LANE_CLK, rlc_pkg::LANE_D0, rlc_pkg::LANE_D1};
        end
        return {rlc_pkg::LANE_CLK, rlc_pkg::LANE_D2, rlc_pkg::LANE_D1, rlc_pkg::LANE_D0};
    endfunction

    // Clock input lane always takes the lowest rate class
    function automatic logic [19:0] exp_adapt(input logic sw, input logic [1:0] r);
        logic [3:0][4:0]        e;
        logic [4:0]             t [4];
        rlc_pkg::rlc_lane_map_t m;
        t = '{rlc_pkg::ADAPT_GAIN_R0, rlc_pkg::ADAPT_GAIN_R1,
              rlc_pkg::ADAPT_GAIN_R2, rlc_pkg::ADAPT_GAIN_R3};
        m = exp_map(sw);
        for (int o = 0; o < 4; o++) begin
            e[o] = (m[o] == rlc_pkg::LANE_CLK) ? t[0] : t[r];
        end
        return e;
    endfunction

    initial begin
        void'($urandom(32'hBB2CDBFD));
        step(4);
        rlc_tb_start: rst_b_i <= 1'b1;
        step(2);
        check("link_oe_b", loe_b, 1);
        check("active", act, 0);
        wait_oe();
        step(3);
        check("active", act, 1);
        check("link_oe_b", loe_b, 0);
        check("pol", pol, 0);
        check("map", lmap, exp_map(0));
        check("gain", gain, {4{rlc_pkg::EQ_GAIN_14DB}});
        eqp <= rlc_pkg::EQP_LOW;
        step(3);
        check("gain", gain, {4{rlc_pkg::EQ_GAIN_7P5DB}});
        fast <= 1'b1;
        eqp <= rlc_pkg::EQP_FLOAT;
        rate <= 2'($urandom);
        wait_cdr(1);
        check("cdr_on_time", (n >= CON - 1) && (n <= CON + 1), 1);
        check("cdr_en", cdr_en, 1);
        step(2);
        check("pol", pol, 1);
        check("adapt", adapt, 1);
        check("gain", gain, exp_adapt(0, rate));
        pin <= 1'b0;
        rate <= 2'($urandom);
        step(3);
        check("map", lmap, exp_map(1));
        check("gain", gain, exp_adapt(1, rate));
        pin <= 1'b1;
        step(3);
        fast <= 1'b0;
        step(1);
        check("cdr_en", cdr_en, 0);
        check("cdr_act", cdr_act, 0);
        step(1);
        check("adapt", adapt, 0);
        pin <= 1'b0;
        fast <= 1'b1;
        step(3);
        check("map", lmap, exp_map(1));
        pin <= 1'b1;
        wait_cdr(1);
        step(2);
        check("pol_lost", pol, 0);
        fast <= 1'b0;
        pin <= 1'b0;
        g = 5'($urandom);
        // Mode first; the later lane write clears the loss
        wr_reg(rlc_pkg::REG_MODE_CTL, {6'h00, rlc_pkg::FM_RETIMER});
        wr_reg(rlc_pkg::REG_LANE_CTL, 8'h40);
        wr_reg(rlc_pkg::REG_EQ_GAIN, {2'h0, g, 1'b0});
        wr_reg(8'h0B, 8'h80);
        wait_cdr(1);
        step(2);
        check("map", lmap, exp_map(0));
        check("pol", pol, 1);
        check("gain", gain, {4{g}});
        wr_reg(rlc_pkg::REG_MODE_CTL, {6'h08, rlc_pkg::FM_REDRIVER});
        step(1);
        check("cdr_en", cdr_en, 0);
        check("adapt", adapt, 0);
        check("gain", gain, {4{g}});
        for (int i = 0; i < 300; i++) begin
            lerr <= 3'($urandom) | 3'h1;
            step(1);
            for (int k = 0; k < 3; k++) begin
                exp_c[k] = (exp_c[k] < 255) ? exp_c[k] + lerr[k] : 255;
            end
        end
        // Clock enable low must freeze the counters
        ce <= 1'b0;
        lerr <= 3'h7;
        step(2);
        ce <= 1'b1;
        lerr <= 3'h0;
        step(2);
        for (int k = 0; k < 3; k++) begin
            check("err_cnt", ecnt[k], exp_c[k]);
        end
        // Hit in the clear cycle is kept
        clr <= 1'b1;
        lerr <= 3'h2;
        step(1);
        clr <= 1'b0;
        lerr <= 3'h0;
        step(1);
        check("err_clr", ecnt, 24'h000100);
        toggle <= 1'b1;
        fast <= 1'b1;
        step(1);
        toggle <= 1'b0;
        step(2);
        check("link_oe_b", loe_b, 1);
        check("active", act, 0);
        wr_reg(rlc_pkg::REG_LANE_CTL, 8'h40);
        wait_oe();
        step(3);
        check("map", lmap, exp_map(1));
        check("pol", pol, 0);
        // Forced redriver forgotten, automatic mode restarts recovery
        check("cdr_en", cdr_en, 1);
        end_of_test();
    end
endmodule
